// [rtl/eltc_pkg.sv]
// Package with shared constants and carrier types for the line trigger control block
package eltc_pkg;

  // ----------------------------------------
  // Register field positions and reset value
  // ----------------------------------------
  localparam int unsigned PIX_SEL_LSB   = 0;
  localparam int unsigned SOS_SRC_BIT   = 2;
  localparam int unsigned HYST_LSB      = 3;
  localparam int unsigned QUAD_BIT      = 5;
  localparam int unsigned BIDIR_BIT     = 6;
  localparam int unsigned ADV_BIT       = 7;
  localparam logic [7:0]  CFG_RESET     = 8'h00;
  localparam int unsigned CFG_MAX       = 255;

  // ----------------------------------------
  // Hysteresis counts, divider and counter widths
  // ----------------------------------------
  localparam logic [7:0]  HYST_CNT_1    = 8'h04;
  localparam logic [7:0]  HYST_CNT_2    = 8'h10;
  localparam logic [7:0]  HYST_CNT_3    = 8'h40;
  localparam int unsigned LINE_CNT_W    = 13;
  localparam int unsigned DIV_W         = 15;
  localparam logic [14:0] DIV_RESET     = 15'h0001;
  localparam int unsigned REPLY_DIGITS  = 5;

  // ----------------------------------------
  // Pixel select modes and acknowledge codes
  // ----------------------------------------
  typedef enum logic [1:0] {
    EL_PIX_NORMAL = 2'b00,
    EL_PIX_STATES = 2'b01,
    EL_PIX_LCNT8  = 2'b10,
    EL_PIX_MIXED  = 2'b11
  } eltc_pix_t;
  localparam logic ACK_OK   = 1'b0;
  localparam logic ACK_FAIL = 1'b1;

  // Configuration register fields
  typedef struct packed {
    logic      advanced_sync_enable;
    logic      bidirectional_enable;
    logic      quad_edge_enable;
    logic [1:0] hysteresis;
    logic      sos_source_select;
    eltc_pix_t pixel_select;
  } eltc_cfg_t;

  // Synchronised sync inputs
  typedef struct packed {
    logic frame_sync;
    logic sync_b;
    logic sync_a;
  } eltc_sync_t;

endpackage

// [rtl/eltc_reply_fmt.sv]
// Binary to five digit ASCII decimal reply formatter
`timescale 1ns/1ns
module eltc_reply_fmt (
  // Clock and reset
  input  wire logic        clk_in,
  input  wire logic        rstn_in,
  // Request
  input  wire logic        start_in,
  input  wire logic [7:0]  value_in,
  // Reply
  output logic             busy_out,
  output logic             done_out,
  output logic [39:0]      ascii_out
);

  typedef struct packed {
    logic [16:0] rem;
    logic [2:0]  idx;
    logic        busy;
    logic        done;
    logic [39:0] text;
  } eltc_fmt_st_t;

  eltc_fmt_st_t s_q;
  eltc_fmt_st_t s_d;

  // Divisor per digit, most significant first
  function automatic logic [16:0] pow10(input logic [2:0] i);
    unique case (i)
      3'd0:    pow10 = 17'h0_2710;
      3'd1:    pow10 = 17'h0_03E8;
      3'd2:    pow10 = 17'h0_0064;
      3'd3:    pow10 = 17'h0_000A;
      default: pow10 = 17'h0_0001;
    endcase
  endfunction

  // One digit per cycle by repeated subtraction of at most nine steps folded into a loop
  always_comb begin
    logic [3:0]  dig;
    logic [16:0] r;
    dig = 4'h0;
    r   = s_q.rem;
    s_d = s_q;
    s_d.done = 1'b0;
    if (start_in && !s_q.busy) begin
      s_d.rem  = {9'h000, value_in};
      s_d.idx  = 3'd0;
      s_d.busy = 1'b1;
    end else if (s_q.busy) begin
      for (int k = 0; k < 9; k++) begin
        if (r >= pow10(s_q.idx)) begin
          r   = r - pow10(s_q.idx);
          dig = dig + 4'h1;
        end
      end
      s_d.rem  = r;
      s_d.text = {s_q.text[31:0], 4'h3, dig};
      if (s_q.idx == 3'(eltc_pkg::REPLY_DIGITS - 1)) begin
        s_d.busy = 1'b0;
        s_d.done = 1'b1;
      end
      s_d.idx = s_q.idx + 3'd1;
    end
  end

  // State register
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign busy_out  = s_q.busy;
  assign done_out  = s_q.done;
  assign ascii_out = s_q.text;

endmodule

// [rtl/eltc_top.sv]
// Line trigger control stage: sync input decode, trigger generation, divider, pixel tagging
`timescale 1ns/1ns
//
// Function
// - Basic mode triggers from the primary sync input only, chosen by bit 7 clear.
// - Advanced mode combines primary and secondary sync inputs under the config register.
// - Config write accepts 0 to 255 and acknowledges 0 for ok, 1 for fail.
// - Config read returns five ASCII decimal digits.
// - Bits 1:0 choose first pixel content: intensity, states, 8-bit or mixed counter.
// - States sit in bits 7:5 as frame, secondary, primary; lower bits zero.
// - Mixed mode puts counter 12:8 in pixel one, 7:0 in pixel two.
// - Bit 2 takes scan start from secondary input in external mode.
// - Bits 4:3 set hysteresis off, 4, 16 or 64 counts.
// - Bit 5 chooses falling primary edge or all four quadrature edges.
// - Bit 6 chooses forward only or both directions.
// - Forward-only mode discards all pulses from reverse motion.
// - Bit 7 clear makes bits 3 to 6 inactive.
// - Generated pulses feed the trigger divider.
// - Divider takes 1 to 32767 and passes one trigger per divisor count.
module eltc_top #(
  parameter int unsigned LCNT_W = eltc_pkg::LINE_CNT_W
) (
  // Clock and reset
  input  wire logic        clk_in,
  input  wire logic        rstn_in,
  // Sync pins
  input  wire logic        sync_a_in,
  input  wire logic        sync_b_in,
  input  wire logic        frame_sync_in,
  // Command port
  input  wire logic        cfg_write_in,
  input  wire logic [15:0] cfg_value_in,
  input  wire logic        div_write_in,
  input  wire logic [15:0] div_value_in,
  input  wire logic        trigger_mode_command_in,
  input  wire logic        read_sync_request_in,
  // Command answers
  output logic             ack_valid_out,
  output logic             ack_out,
  output logic             reply_valid_out,
  output logic [39:0]      reply_ascii_out,
  output logic [7:0]       line_trigger_config_out,
  // Trigger and pixel path
  output logic             trigger_pulse_out,
  output logic             scan_start_out,
  output logic             external_scan_start_out,
  input  wire logic        pixel_valid_in,
  input  wire logic        pixel_first_in,
  input  wire logic [15:0] pixel_in,
  output logic             pixel_valid_out,
  output logic [15:0]      pixel_out
);

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    eltc_pkg::eltc_sync_t meta;
    eltc_pkg::eltc_sync_t sync;
    eltc_pkg::eltc_sync_t prev;
    eltc_pkg::eltc_cfg_t  cfg;
    logic [14:0]          div;
    logic [14:0]          div_cnt;
    logic signed [8:0]    pos;
    logic                 dir_rev;
    logic [LCNT_W-1:0]    lcnt;
    logic                 ack_v;
    logic                 ack;
    logic                 trig;
    logic                 scan_start;
    logic                 ext_sos;
    logic                 pix_v;
    logic                 second;
    logic [15:0]          pix;
  } eltc_st_t;

  eltc_st_t s_q;
  eltc_st_t s_d;

  logic              fmt_busy;
  logic              fmt_done;
  logic [39:0]       fmt_ascii;
  logic [7:0]        hyst;
  logic              raw_pulse;
  logic              step_fwd;
  logic              step_rev;
  logic              gen_pulse;
  logic              sos_edge;
  logic              turn;

  // ----------------------------------------
  // Combinational decode
  // ----------------------------------------

  // Hysteresis count chosen by bits 4:3
  always_comb begin
    unique case (s_q.cfg.hysteresis)
      2'b00:   hyst = 8'h00;
      2'b01:   hyst = eltc_pkg::HYST_CNT_1;
      2'b10:   hyst = eltc_pkg::HYST_CNT_2;
      default: hyst = eltc_pkg::HYST_CNT_3;
    endcase
  end

  // Quadrature step direction; forward when A leads B
  always_comb begin
    logic chg_a;
    logic chg_b;
    chg_a    = s_q.sync.sync_a ^ s_q.prev.sync_a;
    chg_b    = s_q.sync.sync_b ^ s_q.prev.sync_b;
    step_fwd = (chg_a && (s_q.sync.sync_a != s_q.sync.sync_b)) ||
               (chg_b && (s_q.sync.sync_a == s_q.sync.sync_b));
    step_rev = (chg_a || chg_b) && !step_fwd;
    // Single edge counts falling primary only, 4x counts every edge
    if (s_q.cfg.advanced_sync_enable && s_q.cfg.quad_edge_enable) begin
      raw_pulse = chg_a || chg_b;
    end else begin
      raw_pulse = s_q.prev.sync_a && !s_q.sync.sync_a;
    end
  end

  // A step against the last direction opens the hysteresis window, this step included
  assign turn = s_q.cfg.advanced_sync_enable && (step_fwd || step_rev) &&
                (step_rev != s_q.dir_rev) && (hyst != 8'h00);

  // Direction filter and hysteresis gate; bit 7 low bypasses them all
  always_comb begin
    logic rev_now;
    rev_now = s_q.cfg.quad_edge_enable ? step_rev : !s_q.sync.sync_b;
    if (!s_q.cfg.advanced_sync_enable) begin
      gen_pulse = raw_pulse;
    end else if (s_q.pos != 9'sd0 || turn) begin
      gen_pulse = 1'b0;
    end else if (!s_q.cfg.bidirectional_enable && rev_now) begin
      gen_pulse = 1'b0;
    end else begin
      gen_pulse = raw_pulse;
    end
  end

  // Scan start edge source: trigger pulse, or falling secondary in external mode with bit 2 set
  assign sos_edge = (trigger_mode_command_in && s_q.cfg.sos_source_select) ?
                    (s_q.prev.sync_b && !s_q.sync.sync_b) : s_q.trig;

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    s_d       = s_q;
    s_d.meta  = '{frame_sync: frame_sync_in, sync_b: sync_b_in, sync_a: sync_a_in};
    s_d.sync  = s_q.meta;
    s_d.prev  = s_q.sync;
    s_d.ack_v = 1'b0;
    s_d.trig  = 1'b0;
    s_d.scan_start   = sos_edge;
    s_d.ext_sos = trigger_mode_command_in && sos_edge;
    // Register writes with range checked acknowledge
    if (cfg_write_in) begin
      s_d.ack_v = 1'b1;
      if (cfg_value_in <= 16'(eltc_pkg::CFG_MAX)) begin
        s_d.cfg = eltc_pkg::eltc_cfg_t'(cfg_value_in[7:0]);
        s_d.ack = eltc_pkg::ACK_OK;
      end else begin
        s_d.ack = eltc_pkg::ACK_FAIL;
      end
    end else if (div_write_in) begin
      s_d.ack_v = 1'b1;
      if (div_value_in != 16'h0000 && !div_value_in[15]) begin
        s_d.div     = div_value_in[14:0];
        s_d.div_cnt = 15'h0000;
        s_d.ack     = eltc_pkg::ACK_OK;
      end else begin
        s_d.ack = eltc_pkg::ACK_FAIL;
      end
    end
    // Direction is tracked on every advanced-mode step, so enabling hysteresis within advanced mode never compares
    // against a stale direction; the turning step is the first suppressed count
    if (s_q.cfg.advanced_sync_enable && (step_fwd || step_rev)) begin
      s_d.dir_rev = step_rev;
      if (turn) begin
        s_d.pos = 9'(hyst - 8'h01);
      end else if (s_q.pos != 9'sd0) begin
        s_d.pos = s_q.pos - 9'sd1;
      end
    end
    // Divider: pass one trigger per divisor count of generated pulses
    if (gen_pulse) begin
      if (s_q.div_cnt + 15'h0001 >= s_q.div) begin
        s_d.div_cnt = 15'h0000;
        s_d.trig    = 1'b1;
      end else begin
        s_d.div_cnt = s_q.div_cnt + 15'h0001;
      end
    end
    // Line counter wraps naturally at its width
    if (sos_edge) begin
      s_d.lcnt = LCNT_W'(s_q.lcnt + 1'b1);
    end
    // Pixel tagging of the first pixel of a line, and of the second in mixed mode
    s_d.pix_v  = pixel_valid_in;
    s_d.pix    = pixel_in;
    if (pixel_valid_in) begin
      s_d.second = pixel_first_in;
      unique case (s_q.cfg.pixel_select)
        eltc_pkg::EL_PIX_NORMAL: s_d.pix = pixel_in;
        eltc_pkg::EL_PIX_STATES: begin
          if (pixel_first_in) begin
            s_d.pix = {pixel_in[15:8], s_q.sync.frame_sync, s_q.sync.sync_b,
                       s_q.sync.sync_a, 5'b00000};
          end
        end
        eltc_pkg::EL_PIX_LCNT8: begin
          if (pixel_first_in) begin
            s_d.pix = {pixel_in[15:8], s_q.lcnt[7:0]};
          end
        end
        eltc_pkg::EL_PIX_MIXED: begin
          if (pixel_first_in) begin
            s_d.pix = {pixel_in[15:8], s_q.sync.frame_sync, s_q.sync.sync_b,
                       s_q.sync.sync_a, s_q.lcnt[12:8]};
          end else if (s_q.second) begin
            s_d.pix = {pixel_in[15:8], s_q.lcnt[7:0]};
          end
        end
      endcase
    end
  end

  // State register
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      s_q     <= '0;
      s_q.cfg <= eltc_pkg::eltc_cfg_t'(eltc_pkg::CFG_RESET);
      s_q.div <= eltc_pkg::DIV_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------
  // Read reply formatter
  // ----------------------------------------
  eltc_reply_fmt u_fmt (
    .clk_in    (clk_in),
    .rstn_in   (rstn_in),
    .start_in  (read_sync_request_in),
    .value_in  (s_q.cfg),
    .busy_out  (fmt_busy),
    .done_out  (fmt_done),
    .ascii_out (fmt_ascii)
  );

  // Outputs
  assign ack_valid_out           = s_q.ack_v;
  assign ack_out                 = s_q.ack;
  assign reply_valid_out         = fmt_done;
  assign reply_ascii_out         = fmt_ascii;
  assign line_trigger_config_out = s_q.cfg;
  assign trigger_pulse_out       = s_q.trig;
  assign scan_start_out          = s_q.scan_start;
  assign external_scan_start_out = s_q.ext_sos;
  assign pixel_valid_out         = s_q.pix_v;
  assign pixel_out               = s_q.pix;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  sequence s_bad_write;
    cfg_write_in && cfg_value_in > 16'd255;
  endsequence
  property p_cfg_ack;
    @(posedge clk_in) disable iff (!rstn_in)
      s_bad_write |=> ack_valid_out && ack_out == 1'b1;
  endproperty
  a_cfg_ack: assert property (p_cfg_ack) else $error("bad write not refused");

  property p_reply;
    @(posedge clk_in) disable iff (!rstn_in)
      (read_sync_request_in && !fmt_busy) |-> ##6 reply_valid_out;
  endproperty
  a_reply: assert property (p_reply) else $error("reply not on time");

  property p_basic;
    @(posedge clk_in) disable iff (!rstn_in)
      !s_q.cfg.advanced_sync_enable && !(s_q.prev.sync_a && !s_q.sync.sync_a) |-> !gen_pulse;
  endproperty
  a_basic: assert property (p_basic) else $error("pulse without falling primary");

  property p_fwd;
    @(posedge clk_in) disable iff (!rstn_in)
      s_q.cfg.advanced_sync_enable && !s_q.cfg.bidirectional_enable &&
      s_q.cfg.quad_edge_enable && step_rev |-> !gen_pulse;
  endproperty
  a_fwd: assert property (p_fwd) else $error("reverse pulse passed");

  property p_hyst;
    @(posedge clk_in) disable iff (!rstn_in)
      s_q.pos != 9'sd0 && s_q.cfg.advanced_sync_enable |-> !gen_pulse;
  endproperty
  a_hyst: assert property (p_hyst) else $error("pulse inside hysteresis");

  property p_div1;
    @(posedge clk_in) disable iff (!rstn_in)
      gen_pulse && s_q.div == 15'd1 |=> trigger_pulse_out;
  endproperty
  a_div1: assert property (p_div1) else $error("divide by one lost pulse");

  property p_lcnt;
    @(posedge clk_in) disable iff (!rstn_in)
      sos_edge |=> s_q.lcnt == $past(s_q.lcnt) + 1'b1;
  endproperty
  a_lcnt: assert property (p_lcnt) else $error("line counter did not step");

  property p_states;
    @(posedge clk_in) disable iff (!rstn_in)
      pixel_valid_in && pixel_first_in && s_q.cfg.pixel_select == eltc_pkg::EL_PIX_STATES
      |=> pixel_out[4:0] == 5'b00000 && pixel_out[5] == $past(s_q.sync.sync_a);
  endproperty
  a_states: assert property (p_states) else $error("state pixel wrong");

endmodule

// [tb/eltc_enc_model.sv]
// Behavioural machine encoder that drives the primary, secondary and frame sync lines
`timescale 1ns/1ns
module eltc_enc_model (
  // Clock
  input  wire logic clk_in,
  // Sync lines
  output logic      sync_a_out,
  output logic      sync_b_out,
  output logic      frame_sync_out
);
  logic [1:0] phase_q;
  logic       frame_q;

  // Gray coding keeps only one line moving per step, so no false edges appear
  assign sync_a_out     = phase_q[1] ^ phase_q[0];
  assign sync_b_out     = phase_q[1];
  assign frame_sync_out = frame_q;

  initial begin
    phase_q = 2'b00;
    frame_q = 1'b0;
  end

  // One quadrature step; forward lets the primary line lead, then the lines hold
  task step(input bit fwd);
    @(posedge clk_in);
    phase_q <= fwd ? phase_q + 2'd1 : phase_q - 2'd1;
    repeat (10) @(posedge clk_in);
  endtask

  // Frame sync is a plain level from the grabber side
  task set_frame(input logic v);
    @(posedge clk_in);
    frame_q <= v;
    repeat (4) @(posedge clk_in);
  endtask
endmodule

// [tb/eltc_top_test.sv]
// Self-checking testbench of the line trigger control stage
`timescale 1ns/1ns
module eltc_top_test;
  logic        clk_in = 1'b0;
  logic        rstn_in = 1'b0;
  logic        sync_a, sync_b, frame_sync;
  logic        cfg_write_in = 1'b0, div_write_in = 1'b0;
  logic [15:0] cfg_value_in = 16'h0000, div_value_in = 16'h0000;
  logic        trigger_mode_command_in = 1'b0, read_sync_request_in = 1'b0;
  logic        ack_valid_out, ack_out, reply_valid_out;
  logic [39:0] reply_ascii_out;
  logic [7:0]  line_trigger_config_out, cfg_exp = 8'h00;
  logic        trigger_pulse_out, scan_start_out, external_scan_start_out;
  logic        pixel_valid_in = 1'b0, pixel_first_in = 1'b0, pixel_valid_out;
  logic [15:0] pixel_in = 16'h0000, pixel_out;
  int          errors = 0, total_checks = 0, cycles = 0;
  int          trig_cnt = 0, scan_cnt = 0, ext_cnt = 0, lcnt = 0;
  logic [7:0]  st;

  always #25 clk_in = ~clk_in;

  eltc_enc_model i_enc (.clk_in(clk_in), .sync_a_out(sync_a), .sync_b_out(sync_b),
                        .frame_sync_out(frame_sync));

  eltc_top i_dut (
    .clk_in(clk_in), .rstn_in(rstn_in), .sync_a_in(sync_a), .sync_b_in(sync_b),
    .frame_sync_in(frame_sync), .cfg_write_in(cfg_write_in), .cfg_value_in(cfg_value_in),
    .div_write_in(div_write_in), .div_value_in(div_value_in),
    .trigger_mode_command_in(trigger_mode_command_in),
    .read_sync_request_in(read_sync_request_in), .ack_valid_out(ack_valid_out),
    .ack_out(ack_out), .reply_valid_out(reply_valid_out), .reply_ascii_out(reply_ascii_out),
    .line_trigger_config_out(line_trigger_config_out),
    .trigger_pulse_out(trigger_pulse_out), .scan_start_out(scan_start_out),
    .external_scan_start_out(external_scan_start_out), .pixel_valid_in(pixel_valid_in),
    .pixel_first_in(pixel_first_in), .pixel_in(pixel_in),
    .pixel_valid_out(pixel_valid_out), .pixel_out(pixel_out));

  // ------------------------------------------------------------
  // Counters, watchdog and shared tasks
  // ------------------------------------------------------------
  // Pulses stand one cycle, so count them at every edge
  always @(posedge clk_in) begin
    if (trigger_pulse_out === 1'b1) trig_cnt++;
    if (scan_start_out === 1'b1) scan_cnt++;
    if (external_scan_start_out === 1'b1) ext_cnt++;
    cycles++;
    if (cycles == 20000) begin
      errors++;
      stop_test();
    end
  end

  task check(input logic [39:0] got, input logic [39:0] exp);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Config or divider write; a refused value must leave the config alone
  task wr(input bit div, input logic [15:0] v, input logic exp_ack);
    @(posedge clk_in);
    if (div) begin
      div_write_in <= 1'b1;
      div_value_in <= v;
    end else begin
      cfg_write_in <= 1'b1;
      cfg_value_in <= v;
    end
    @(posedge clk_in);
    div_write_in <= 1'b0;
    cfg_write_in <= 1'b0;
    // Acknowledge stands exactly in the cycle after the taking edge
    @(negedge clk_in);
    check(ack_valid_out, 1'b1);
    check(ack_out, exp_ack);
    if (!div && exp_ack == eltc_pkg::ACK_OK) cfg_exp = v[7:0];
    check(line_trigger_config_out, cfg_exp);
  endtask

  task rd(input logic [39:0] exp);
    @(posedge clk_in);
    read_sync_request_in <= 1'b1;
    @(posedge clk_in);
    read_sync_request_in <= 1'b0;
    // Reply pulse stands in the sixth cycle after the taking edge
    repeat (5) @(posedge clk_in);
    @(negedge clk_in);
    check(reply_valid_out, 1'b1);
    check(reply_ascii_out, exp);
  endtask

  // Encoder steps, then the number of generated triggers
  task run(input int n, input bit fwd, input int exp);
    trig_cnt = 0;
    scan_cnt = 0;
    ext_cnt = 0;
    repeat (n) i_enc.step(fwd);
    check(trig_cnt, exp);
    if (!trigger_mode_command_in) lcnt += exp;
  endtask

  task pix(input logic [7:0] e1, input logic [7:0] e2);
    @(posedge clk_in);
    pixel_valid_in <= 1'b1;
    pixel_first_in <= 1'b1;
    pixel_in <= 16'hA5C3;
    @(posedge clk_in);
    pixel_first_in <= 1'b0;
    pixel_in <= 16'h5A3C;
    @(negedge clk_in);
    check(pixel_out[7:0], e1);
    check(pixel_valid_out, 1'b1);
    @(posedge clk_in);
    pixel_valid_in <= 1'b0;
    @(negedge clk_in);
    check(pixel_out[7:0], e2);
  endtask

  task stop_test();
    if (errors == 0 && total_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    repeat (20) @(posedge clk_in);
    rstn_in <= 1'b1;
    @(negedge clk_in);
    check(line_trigger_config_out, eltc_pkg::CFG_RESET);
    rd(40'h3030_3030_30);
    wr(0, 16'd255, eltc_pkg::ACK_OK);
    rd(40'h3030_3235_35);
    wr(0, 16'd256, eltc_pkg::ACK_FAIL);
    wr(0, 16'd232, eltc_pkg::ACK_OK);
    rd(40'h3030_3233_32);
    wr(0, 16'h0000, eltc_pkg::ACK_OK);
    run(4, 1, 1);
    wr(0, 16'h0080, eltc_pkg::ACK_OK);
    run(4, 1, 1);
    run(4, 0, 0);
    wr(0, 16'h00C0, eltc_pkg::ACK_OK);
    run(4, 0, 1);
    wr(0, 16'h0020, eltc_pkg::ACK_OK);
    run(4, 1, 1);
    wr(0, 16'h00A0, eltc_pkg::ACK_OK);
    run(4, 0, 0);
    run(4, 1, 4);
    wr(0, 16'h00E8, eltc_pkg::ACK_OK);
    run(4, 1, 4);
    run(8, 0, 4);
    wr(0, 16'h00E0, eltc_pkg::ACK_OK);
    wr(1, 16'h0000, eltc_pkg::ACK_FAIL);
    wr(1, 16'h8000, eltc_pkg::ACK_FAIL);
    wr(1, 16'h0003, eltc_pkg::ACK_OK);
    run(8, 1, 2);
    wr(1, 16'h0001, eltc_pkg::ACK_OK);
    // Secondary line as scan start: primary falls first, secondary falls last
    wr(0, 16'h0004, eltc_pkg::ACK_OK);
    @(posedge clk_in);
    trigger_mode_command_in <= 1'b1;
    run(3, 1, 1);
    check(scan_cnt, 0);
    check(ext_cnt, 0);
    run(1, 1, 0);
    check(scan_cnt, 1);
    check(ext_cnt, 1);
    lcnt += 1;
    trigger_mode_command_in <= 1'b0;
    // Diagnostic pixels with primary high, secondary low, frame high
    i_enc.step(1);
    i_enc.set_frame(1'b1);
    st = {frame_sync, sync_b, sync_a, 5'h00};
    wr(0, 16'h0000, eltc_pkg::ACK_OK);
    pix(8'hC3, 8'h3C);
    wr(0, 16'h0001, eltc_pkg::ACK_OK);
    pix(st, 8'h3C);
    wr(0, 16'h0002, eltc_pkg::ACK_OK);
    pix(lcnt[7:0], 8'h3C);
    wr(0, 16'h0003, eltc_pkg::ACK_OK);
    pix(st | {3'b000, lcnt[12:8]}, lcnt[7:0]);
    stop_test();
  end
endmodule
